// *** standby_extmem_defs.svh ***
// Purpose: offsets, field positions, reset values, row shift codes and bank numbers for the standby / external memory block
// Assumes: 8-bit register port, word index addressing
// Notes: definitions only
`ifndef STANDBY_EXTMEM_DEFS_SVH
`define STANDBY_EXTMEM_DEFS_SVH

// register offsets
`define OFS_STANDBY_CONTROL 4'h0
`define OFS_REFRESH_CONTROL 4'h1
`define OFS_BUS_WIDTH 4'h2
`define OFS_BUS_ACCESS 4'h3
`define OFS_DRAM_BANK2_CONTROL 4'h4
`define OFS_STATUS 4'h5
`define OFS_WAKE 4'h6

// field positions
`define BIT_HALT_REQ 0
`define BIT_STOP_REQ 1
`define BIT_SELF_REFRESH_ON_STOP 0
`define BIT_BANK1_WIDTH 1
`define BIT_BANK2_WIDTH 2
`define BIT_BANK1_STROBE_STYLE 1
`define BIT_DRAM_STROBE_STYLE 0
`define LSB_ROW_SHIFT 1

// reset values
`define RST_BUS_WIDTH 8'h00
`define RST_BUS_ACCESS 8'h00
`define RST_DRAM_BANK2_CONTROL 8'h00
`define RST_FETCH_ADDR 24'h000000

// row shift field codes and shift amounts
`define ROW_SHIFT_CODE_9 2'h1
`define ROW_SHIFT_9 5'h09
`define ROW_SHIFT_CODE_8 2'h0
`define ROW_SHIFT_8 5'h08
`define ROW_SHIFT_CODE_10 2'h2
`define ROW_SHIFT_10 5'h0A
`define ROW_SHIFT_11 5'h0B

// bank numbers
`define BANK_ROM 2'h0
`define BANK_SRAM 2'h1
`define BANK_DRAM2 2'h2
`define BANK_DRAM3 2'h3

`endif

// *** standby_extmem_pkg.sv ***
// Purpose: types shared by the standby / external memory block
// Assumes: constants live in standby_extmem_defs.svh
// Notes: none
package standby_extmem_pkg;

	// standby sequencer states, one-hot
	typedef enum logic [4:0] {
		ST_RUN = 5'h01,
		ST_WAIT_END = 5'h02,
		ST_SELF_REF = 5'h04,
		ST_HALT = 5'h08,
		ST_STOP = 5'h10
	} standby_state_e;

	// one internal bus cycle request
	typedef struct packed {
		logic valid;
		logic write;
		logic [1:0] bank;
		logic [21:0] addr;
		logic [1:0] byte_en;
	} mem_req_s;

	// external memory control strobes, all active low
	typedef struct packed {
		logic write_enable_low_n;
		logic write_enable_high_n;
		logic column_strobe_low_n;
		logic column_strobe_high_n;
		logic row_strobe_n;
		logic dram_write_enable_n;
		logic dram_output_enable_n;
	} mem_strobe_s;

endpackage : standby_extmem_pkg

// *** strobe_decode.sv ***
// Purpose: static bank fitting: address lanes, byte strobes, DRAM row address
// Assumes: request is held for the whole bus cycle
// Notes: combinational; registering is done by the caller
module strobe_decode (
	// configuration
	input wire logic boot_bus_width_pin,
	input wire logic bank1_width_bit,
	input wire logic bank1_strobe_style_bit,
	input wire logic bank2_width_bit,
	input wire logic dram_strobe_style_bit,
	input wire logic [1:0] row_shift_field,
	// request
	input wire standby_extmem_pkg::mem_req_s req,
	input wire logic cas_phase,
	// results
	output logic [23:0] ext_addr,
	output logic [21:0] row_addr,
	output logic is_wide,
	output standby_extmem_pkg::mem_strobe_s strobe
);
`include "standby_extmem_defs.svh"

	// shift amount lookup, used by the row address path
	function automatic logic [4:0] row_shift_of(input logic [1:0] code);
		case (code)
			`ROW_SHIFT_CODE_8: row_shift_of = `ROW_SHIFT_8;
			`ROW_SHIFT_CODE_9: row_shift_of = `ROW_SHIFT_9;
			`ROW_SHIFT_CODE_10: row_shift_of = `ROW_SHIFT_10;
			default: row_shift_of = `ROW_SHIFT_11;
		endcase
	endfunction : row_shift_of

	wire is_dram = req.bank[1];
	wire is_sram = (req.bank == `BANK_SRAM);
	wire wr = req.valid & req.write;

	// bank width select
	assign is_wide = (req.bank == `BANK_ROM) ? boot_bus_width_pin :
		is_sram ? bank1_width_bit :
		bank2_width_bit;

	// wide bus: word address moves up one line, bit 0 idle; narrow: byte address from line 0, top two lines zero
	assign ext_addr = is_wide ? {1'b0, req.addr, 1'b0} : {2'b00, req.addr};

	// row address from the programmed shift
	assign row_addr = req.addr >> row_shift_of(row_shift_field);

	// sram byte write enables; single-enable style drives both lanes together
	wire sram_wl = wr & is_sram & (bank1_strobe_style_bit ? 1'b1 : req.byte_en[0]);
	wire sram_wh = wr & is_sram & (bank1_strobe_style_bit ? 1'b1 : req.byte_en[1]);
	assign strobe.write_enable_low_n = ~sram_wl;
	assign strobe.write_enable_high_n = ~sram_wh;

	// dram: per-byte column strobes with one shared write enable
	wire dram_act = req.valid & is_dram;
	wire cas_l = dram_act & cas_phase & (dram_strobe_style_bit ? 1'b1 : req.byte_en[0]);
	wire cas_h = dram_act & cas_phase & (dram_strobe_style_bit ? 1'b1 : req.byte_en[1]);
	assign strobe.column_strobe_low_n = ~cas_l;
	assign strobe.column_strobe_high_n = ~cas_h;
	assign strobe.row_strobe_n = ~dram_act;
	// early write: enable is low from row phase on, before any column strobe
	assign strobe.dram_write_enable_n = ~(dram_act & req.write);
	assign strobe.dram_output_enable_n = 1'b0;

endmodule : strobe_decode

// *** standby_extmem.sv ***
// Purpose: standby entry, bus release arbitration and bank fitting of the external memory controller
// Assumes: inputs synchronous to REF_CLK; internal master holds its request until done
// Notes: registers reached over a plain 8-bit address/strobe port
//
// Overview of operation
// - halt entered after current bus cycle ends
// - halted controller still grants bus to externals
// - stop entered after current bus cycle ends
// - self-refresh strobes asserted before stop entry
// - stop grants no new external bus requests
// - no CAS-before-RAS refresh during stop
// - pin low: bank 0 byte-wide, byte addresses
// - pin high: bank 0 word-wide, bit0 unused
// - reset starts fetch at ROM address zero
// - bank 1 width bit selects 16-bit bus
// - bank 1 style 0 gives two write enables
// - bank 2 width bit selects 16-bit bus
// - DRAM early write; output enable held active
// - DRAM style 0: two column strobes, one WE
// - shift code 01 gives row shift nine
// - bus request granted once internals yield; float pins
// - self-refresh-on-stop clears on write0, DRAM access, release
//
// The placing of the registers and strobed register access were chosen for this implementation.
module standby_extmem (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST_B,
	// register port
	input wire logic [3:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	// internal master
	input wire standby_extmem_pkg::mem_req_s CPU_REQ,
	output logic CPU_DONE,
	output logic CPU_HALTED,
	// refresh request from the refresh timer
	input wire logic CBR_REQ,
	output logic CBR_ACTIVE,
	// strap
	input wire logic BOOT_BUS_WIDTH_PIN,
	// external bus
	input wire logic EXT_BUS_REQUEST_N,
	output logic EXT_BUS_GRANT_N,
	output logic PINS_OE,
	output logic [23:0] EXT_ADDR,
	output logic [21:0] ROW_ADDR,
	output logic EXT_WIDE,
	output standby_extmem_pkg::mem_strobe_s STROBE,
	output logic [23:0] FETCH_ADDR
);
`include "standby_extmem_defs.svh"

	// configuration registers
	logic halt_request_bit; // standby control bit 0
	logic stop_request_bit; // standby control bit 1
	logic self_refresh_on_stop_bit; // refresh control bit 0
	logic [7:0] bus_width_reg; // bank widths
	logic [7:0] bus_access_reg; // bank strobe styles
	logic [7:0] dram_bank2_control_reg; // dram style and row shift
	logic [7:0] rdata; // read data flop
	standby_extmem_pkg::standby_state_e state; // standby sequencer
	standby_extmem_pkg::standby_state_e next_state;
	logic granted; // external master owns the bus
	logic cyc_busy; // internal bus cycle in progress
	logic cas_phase; // second half of an internal bus cycle
	logic [23:0] ext_addr;
	logic [21:0] row_addr;
	logic is_wide;
	standby_extmem_pkg::mem_strobe_s strobe;

	// write decode
	wire wr_sby = REG_WR & (REG_ADDR == `OFS_STANDBY_CONTROL);
	wire wr_rf = REG_WR & (REG_ADDR == `OFS_REFRESH_CONTROL);
	wire wr_bw = REG_WR & (REG_ADDR == `OFS_BUS_WIDTH);
	wire wr_ba = REG_WR & (REG_ADDR == `OFS_BUS_ACCESS);
	wire wr_dr = REG_WR & (REG_ADDR == `OFS_DRAM_BANK2_CONTROL);
	wire wr_wake = REG_WR & (REG_ADDR == `OFS_WAKE);

	// state flags
	wire in_run = (state == standby_extmem_pkg::ST_RUN);
	wire in_stop = (state == standby_extmem_pkg::ST_STOP);
	wire in_halt = (state == standby_extmem_pkg::ST_HALT);
	wire stopping = stop_request_bit | (state == standby_extmem_pkg::ST_SELF_REF) | in_stop;
	wire ext_req = ~EXT_BUS_REQUEST_N;

	// grant only when the internal master is idle; stop blocks arbitration
	wire grant_ok = ext_req & ~cyc_busy & ~stopping & ~CBR_ACTIVE;
	wire release_seen = grant_ok & ~granted;
	wire dram_access = CPU_REQ.valid & CPU_REQ.bank[1] & in_run & ~granted;
	// refresh is blocked in stop and during self-refresh entry
	wire cbr_go = CBR_REQ & ~stopping & ~cyc_busy;
	wire start_cyc = CPU_REQ.valid & in_run & ~granted & ~CBR_ACTIVE & ~cyc_busy;

	// bank fitting
	strobe_decode u_decode (
		.boot_bus_width_pin(BOOT_BUS_WIDTH_PIN),
		.bank1_width_bit(bus_width_reg[`BIT_BANK1_WIDTH]),
		.bank1_strobe_style_bit(bus_access_reg[`BIT_BANK1_STROBE_STYLE]),
		.bank2_width_bit(bus_width_reg[`BIT_BANK2_WIDTH]),
		.dram_strobe_style_bit(dram_bank2_control_reg[`BIT_DRAM_STROBE_STYLE]),
		.row_shift_field(dram_bank2_control_reg[`LSB_ROW_SHIFT +: 2]),
		.req(CPU_REQ),
		.cas_phase(cas_phase),
		.ext_addr(ext_addr),
		.row_addr(row_addr),
		.is_wide(is_wide),
		.strobe(strobe)
	);

	// standby sequencer
	always_comb begin
		next_state = state;
		case (state)
			standby_extmem_pkg::ST_RUN: begin
				if (halt_request_bit | stop_request_bit)
					next_state = standby_extmem_pkg::ST_WAIT_END;
			end
			standby_extmem_pkg::ST_WAIT_END: begin
				// current cycle must finish first
				if (~cyc_busy & ~CBR_ACTIVE) begin
					if (stop_request_bit)
						next_state = self_refresh_on_stop_bit ? standby_extmem_pkg::ST_SELF_REF
							: standby_extmem_pkg::ST_STOP;
					else
						next_state = standby_extmem_pkg::ST_HALT;
				end
			end
			standby_extmem_pkg::ST_SELF_REF: begin
				// one cycle with both strobes low, once any external owner has left
				if (~granted)
					next_state = standby_extmem_pkg::ST_STOP;
			end
			standby_extmem_pkg::ST_HALT: begin
				if (~halt_request_bit)
					next_state = standby_extmem_pkg::ST_RUN;
			end
			standby_extmem_pkg::ST_STOP: begin
				if (~stop_request_bit)
					next_state = standby_extmem_pkg::ST_RUN;
			end
			default: next_state = standby_extmem_pkg::ST_RUN;
		endcase
	end

	// sequencer and bus ownership flops
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			state <= standby_extmem_pkg::ST_RUN;
			granted <= 1'b0;
			CBR_ACTIVE <= 1'b0;
		end else begin
			state <= next_state;
			granted <= granted ? ext_req & ~CBR_REQ : grant_ok; // refresh takes the bus back
			CBR_ACTIVE <= cbr_go & ~granted;
		end
	end

	// internal cycle: two clocks, row phase then column phase
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			cyc_busy <= 1'b0;
			cas_phase <= 1'b0;
		end else begin
			cyc_busy <= start_cyc | (cyc_busy & ~cas_phase);
			cas_phase <= cyc_busy & ~cas_phase;
		end
	end

	// standby control register; wake write clears both requests
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			halt_request_bit <= 1'b0;
			stop_request_bit <= 1'b0;
		end else if (wr_sby) begin
			halt_request_bit <= REG_WDATA[`BIT_HALT_REQ];
			stop_request_bit <= REG_WDATA[`BIT_STOP_REQ];
		end else if (wr_wake) begin
			halt_request_bit <= 1'b0;
			stop_request_bit <= 1'b0;
		end
	end

	// self-refresh-on-stop bit; software set loses to hardware clear only within the same cycle
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B)
			self_refresh_on_stop_bit <= 1'b0;
		else if (dram_access | release_seen)
			self_refresh_on_stop_bit <= 1'b0;
		else if (wr_rf)
			self_refresh_on_stop_bit <= REG_WDATA[`BIT_SELF_REFRESH_ON_STOP];
	end

	// static bank settings
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			bus_width_reg <= `RST_BUS_WIDTH;
			bus_access_reg <= `RST_BUS_ACCESS;
			dram_bank2_control_reg <= `RST_DRAM_BANK2_CONTROL;
		end else begin
			if (wr_bw)
				bus_width_reg <= REG_WDATA;
			if (wr_ba)
				bus_access_reg <= REG_WDATA;
			if (wr_dr)
				dram_bank2_control_reg <= REG_WDATA;
		end
	end

	// read mux, answered one cycle later; unmapped reads zero
	wire [7:0] status_byte = {2'b00, state, granted};
	wire [7:0] read_mux =
		(REG_ADDR == `OFS_STANDBY_CONTROL) ? {6'h00, stop_request_bit, halt_request_bit} :
		(REG_ADDR == `OFS_REFRESH_CONTROL) ? {7'h00, self_refresh_on_stop_bit} :
		(REG_ADDR == `OFS_BUS_WIDTH) ? bus_width_reg :
		(REG_ADDR == `OFS_BUS_ACCESS) ? bus_access_reg :
		(REG_ADDR == `OFS_DRAM_BANK2_CONTROL) ? dram_bank2_control_reg :
		(REG_ADDR == `OFS_STATUS) ? status_byte : 8'h00;

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B)
			rdata <= 8'h00;
		else
			rdata <= REG_RD ? read_mux : 8'h00;
	end
	assign REG_RDATA = rdata;

	// pin outputs, registered; float while an external master owns the bus
	wire self_ref_now = (state == standby_extmem_pkg::ST_SELF_REF) & ~granted;
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			EXT_ADDR <= `RST_FETCH_ADDR;
			ROW_ADDR <= 22'h000000;
			EXT_WIDE <= 1'b0;
			STROBE <= '1;
			STROBE.dram_output_enable_n <= 1'b0;
			PINS_OE <= 1'b1;
			EXT_BUS_GRANT_N <= 1'b1;
		end else begin
			PINS_OE <= ~(granted | grant_ok);
			EXT_BUS_GRANT_N <= ~(granted ? ext_req & ~CBR_REQ : grant_ok);
			EXT_WIDE <= is_wide;
			ROW_ADDR <= row_addr;
			EXT_ADDR <= cyc_busy ? ext_addr : EXT_ADDR;
			if (self_ref_now) begin
				STROBE <= '1;
				STROBE.row_strobe_n <= 1'b0;
				STROBE.column_strobe_low_n <= 1'b0;
				STROBE.column_strobe_high_n <= 1'b0;
				STROBE.dram_output_enable_n <= 1'b0;
			end else if (CBR_ACTIVE) begin
				STROBE <= '1;
				STROBE.row_strobe_n <= 1'b0;
				STROBE.column_strobe_low_n <= 1'b0;
				STROBE.column_strobe_high_n <= 1'b0;
				STROBE.dram_output_enable_n <= 1'b0;
			end else if (cyc_busy)
				STROBE <= strobe;
			else begin
				STROBE <= '1;
				STROBE.dram_output_enable_n <= 1'b0;
			end
		end
	end

	// fetch pointer starts at zero in bank 0
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B)
			FETCH_ADDR <= `RST_FETCH_ADDR;
		else if (cas_phase & ~CPU_REQ.write & (CPU_REQ.bank == `BANK_ROM))
			FETCH_ADDR <= ext_addr;
	end

	assign CPU_DONE = cas_phase;
	assign CPU_HALTED = in_halt | in_stop;

endmodule : standby_extmem

// *** standby_extmem_asserts.sv ***
// Purpose: port-level checks for the standby / external memory block
// Assumes: one clock domain, RST_B asynchronous active low
// Notes: bound from the testbench top file
module standby_extmem_asserts (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST_B,
	// internal master
	input wire standby_extmem_pkg::mem_req_s CPU_REQ,
	input wire logic CPU_DONE,
	input wire logic CPU_HALTED,
	// strap and external bus
	input wire logic BOOT_BUS_WIDTH_PIN,
	input wire logic EXT_BUS_REQUEST_N,
	input wire logic EXT_BUS_GRANT_N,
	input wire logic PINS_OE,
	input wire logic [23:0] EXT_ADDR,
	input wire logic EXT_WIDE,
	input wire standby_extmem_pkg::mem_strobe_s STROBE
);
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_B);
	// request held over the start cycle and the row phase
	sequence s_req_held;
		$past(CPU_REQ.valid, 2) && $past(CPU_REQ.valid, 1);
	endsequence
	// column strobe starts a write phase
	sequence s_col_write;
		$fell(STROBE.column_strobe_low_n) && !STROBE.dram_write_enable_n;
	endsequence
	chk_done_cause: assert property (CPU_DONE |-> s_req_held)
		else $error("cycle end without a held request");
	chk_halt_no_cycle: assert property (CPU_HALTED |-> !CPU_DONE)
		else $error("bus cycle ends while halted");
	chk_grant_cause: assert property ($fell(EXT_BUS_GRANT_N) |-> $past(EXT_BUS_REQUEST_N) == 1'b0)
		else $error("grant without request");
	chk_grant_float: assert property (!EXT_BUS_GRANT_N |-> !PINS_OE)
		else $error("pins driven while granted");
	chk_bank0_width: assert property (CPU_DONE && CPU_REQ.bank == 2'h0 |-> EXT_WIDE == BOOT_BUS_WIDTH_PIN)
		else $error("bank 0 width differs from strap");
	chk_wide_lane: assert property (CPU_DONE && EXT_WIDE |-> EXT_ADDR == {1'b0, CPU_REQ.addr, 1'b0})
		else $error("wide address lane wrong");
	chk_narrow_lane: assert property (CPU_DONE && !EXT_WIDE |-> EXT_ADDR == {2'b00, CPU_REQ.addr})
		else $error("byte address lane wrong");
	chk_early_write: assert property (s_col_write |-> $past(STROBE.dram_write_enable_n) == 1'b0)
		else $error("write enable not ahead of column strobe");
	chk_oe_held: assert property (STROBE.dram_output_enable_n == 1'b0)
		else $error("dram output enable released");
endmodule : standby_extmem_asserts

// *** ext_master.sv ***
// Purpose: external bus master that asks for the bus
// Assumes: grant is active low and registered
// Notes: no data traffic, only the request handshake
module ext_master (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// bench control and bus
	input wire logic want,
	input wire logic grant_n,
	output logic request_n
);
	logic held; // grant seen last cycle
	// request follows want; yield at once when grant is taken back
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			request_n <= 1'b1;
			held <= 1'b0;
		end else begin
			held <= !grant_n;
			request_n <= (held && grant_n) ? 1'b1 : !want;
		end
	end
endmodule : ext_master

// *** test_standby_extmem.sv ***
// Purpose: self-checking bench for standby entry and bank fitting
// Assumes: 20 MHz clock, reset held 8 cycles
// Notes: partner is ext_master
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
	$display("ERROR %0t: got %0h expected %0h", $time, got, exp); end end
bind standby_extmem standby_extmem_asserts u_chk (.REF_CLK, .RST_B, .CPU_REQ, .CPU_DONE, .CPU_HALTED,
	.BOOT_BUS_WIDTH_PIN, .EXT_BUS_REQUEST_N, .EXT_BUS_GRANT_N, .PINS_OE, .EXT_ADDR, .EXT_WIDE, .STROBE);
module test_standby_extmem;
	timeunit 1ns;
	timeprecision 1ns;
	// stimulus, all set at time zero
	logic REF_CLK = 1'b0;
	logic RST_B = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	standby_extmem_pkg::mem_req_s cpu_req = '0;
	logic cbr_req = 1'b0;
	logic boot_pin = 1'b0;
	logic want = 1'b0;
	// design outputs
	logic [7:0] reg_rdata;
	logic cpu_done, cpu_halted, cbr_active, grant_n, req_n, pins_oe, ext_wide;
	logic [23:0] ext_addr, fetch_addr;
	logic [21:0] row_addr;
	standby_extmem_pkg::mem_strobe_s strobe, cap_s;
	// captures and counters
	logic [23:0] cap_a;
	logic [21:0] cap_r;
	logic cap_w;
	logic [7:0] rd;
	logic sr_seen = 1'b0;
	int num_errors = 0;
	int cmp_count = 0;
	always #25 REF_CLK = ~REF_CLK;
	standby_extmem u_standby_extmem (.REF_CLK(REF_CLK), .RST_B(RST_B), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .CPU_REQ(cpu_req),
		.CPU_DONE(cpu_done), .CPU_HALTED(cpu_halted), .CBR_REQ(cbr_req), .CBR_ACTIVE(cbr_active),
		.BOOT_BUS_WIDTH_PIN(boot_pin), .EXT_BUS_REQUEST_N(req_n), .EXT_BUS_GRANT_N(grant_n),
		.PINS_OE(pins_oe), .EXT_ADDR(ext_addr), .ROW_ADDR(row_addr), .EXT_WIDE(ext_wide),
		.STROBE(strobe), .FETCH_ADDR(fetch_addr));
	ext_master u_ext_master (.clk(REF_CLK), .rst_b(RST_B), .want(want), .grant_n(grant_n), .request_n(req_n));
	// row and column strobes low together mark self-refresh
	always @(posedge REF_CLK) begin
		if (strobe.row_strobe_n === 1'b0 && strobe.column_strobe_low_n === 1'b0) begin
			sr_seen = 1'b1;
		end
	end
	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge REF_CLK);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge REF_CLK);
		reg_wr <= 1'b0;
	endtask : reg_write
	// data stands only in the cycle after the read edge
	task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
		@(posedge REF_CLK);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge REF_CLK);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : reg_read
	// one cycle, all bytes unless be is given; bank 0 reads, others write
	task automatic cpu_cycle(input logic [1:0] bank, input logic [21:0] a, input logic [1:0] be = 2'h3);
		@(posedge REF_CLK);
		cpu_req <= '{valid: 1'b1, write: (bank != 2'h0), bank: bank, addr: a, byte_en: be};
		for (int i = 0; i < 20 && cpu_done !== 1'b1; i++) begin
			@(posedge REF_CLK);
			#1;
		end
		`CHK(cpu_done, 1'b1)
		cap_a = ext_addr;
		cap_r = row_addr;
		cap_w = ext_wide;
		@(posedge REF_CLK);
		cpu_req <= '0;
		// column phase strobes are registered at the closing edge
		#1 cap_s = strobe;
	endtask : cpu_cycle
	task automatic wait_grant(input logic exp);
		for (int i = 0; i < 12 && grant_n !== exp; i++) begin
			@(posedge REF_CLK);
			#1;
		end
	endtask : wait_grant
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : test_done
	// watchdog, far above the hundred or so cycles the tests take
	initial begin
		repeat (3000) @(posedge REF_CLK);
		num_errors++;
		test_done;
	end
	initial begin
		repeat (8) @(posedge REF_CLK);
		RST_B <= 1'b1;
		#1 `CHK(fetch_addr, 24'h000000)
		`CHK(grant_n, 1'b1)
		reg_read(4'h2, rd);
		`CHK(rd, 8'h00)
		reg_read(4'hF, rd);
		`CHK(rd, 8'h00)
		$display("test reset done");
		cpu_cycle(2'h0, 22'h2AB);
		`CHK(cap_a, {2'b00, 22'h2AB})
		`CHK(fetch_addr, {2'b00, 22'h2AB})
		boot_pin <= 1'b1;
		cpu_cycle(2'h0, 22'h2AB);
		`CHK(cap_a, {1'b0, 22'h2AB, 1'b0})
		reg_write(4'h2, 8'h06);
		reg_write(4'h3, 8'h00);
		reg_write(4'h4, 8'h02);
		reg_write(4'h1, 8'h01);
		cpu_cycle(2'h1, 22'h155);
		`CHK(cap_w, 1'b1)
		`CHK({cap_s.write_enable_low_n, cap_s.write_enable_high_n}, 2'b00)
		cpu_cycle(2'h1, 22'h155, 2'h1);
		`CHK({cap_s.write_enable_low_n, cap_s.write_enable_high_n}, 2'b01)
		cpu_cycle(2'h2, 22'h2A5A5);
		`CHK(cap_w, 1'b1)
		`CHK(cap_r, 22'h2A5A5 >> 9)
		`CHK({cap_s.column_strobe_low_n, cap_s.column_strobe_high_n, cap_s.dram_write_enable_n}, 3'b000)
		`CHK(cap_s.dram_output_enable_n, 1'b0)
		cpu_cycle(2'h2, 22'h2A5A5, 2'h2);
		`CHK({cap_s.column_strobe_low_n, cap_s.column_strobe_high_n, cap_s.dram_write_enable_n}, 3'b100)
		reg_read(4'h1, rd);
		`CHK(rd[0], 1'b0)
		$display("test bank fitting done");
		reg_write(4'h1, 8'h01);
		fork
			cpu_cycle(2'h0, 22'h010);
			reg_write(4'h0, 8'h01);
		join
		repeat (2) @(posedge REF_CLK);
		#1 `CHK(cpu_halted, 1'b1)
		@(posedge REF_CLK);
		want <= 1'b1;
		wait_grant(1'b0);
		`CHK(grant_n, 1'b0)
		`CHK(pins_oe, 1'b0)
		reg_read(4'h1, rd);
		`CHK(rd[0], 1'b0)
		@(posedge REF_CLK);
		want <= 1'b0;
		wait_grant(1'b1);
		`CHK(grant_n, 1'b1)
		// pins stay floated one cycle after the grant drops
		@(posedge REF_CLK);
		#1 `CHK(pins_oe, 1'b1)
		reg_write(4'h0, 8'h00);
		$display("test halt done");
		reg_write(4'h1, 8'h01);
		sr_seen = 1'b0;
		reg_write(4'h0, 8'h03);
		repeat (3) @(posedge REF_CLK);
		reg_read(4'h5, rd);
		`CHK(rd, {2'b00, standby_extmem_pkg::ST_STOP, 1'b0})
		`CHK(sr_seen, 1'b1)
		@(posedge REF_CLK);
		want <= 1'b1;
		cbr_req <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			@(posedge REF_CLK);
			#1 `CHK(grant_n, 1'b1)
			`CHK(cbr_active, 1'b0)
		end
		@(posedge REF_CLK);
		want <= 1'b0;
		cbr_req <= 1'b0;
		reg_write(4'h0, 8'h00);
		reg_write(4'h1, 8'h00);
		$display("test stop done");
		test_done;
	end
endmodule : test_standby_extmem
